// ---- core/tsvr_trap_status.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsvr_regs.svh"
// ==========================================================
// Trap flags and vector status reporting
module tsvr_trap_status (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Trap events, one cycle pulses
  input wire logic mem_double_error_event,
  input wire logic soft_hard_trap_event,
  // Interrupt controller state
  input wire logic pend_valid,
  input wire logic [7:0] pend_vec,
  input wire logic [3:0] pend_level,
  input wire logic [2:0] priority_level_low,
  input wire logic priority_level_msb,
  // CPU acknowledge
  input wire logic cpu_ack,
  input wire logic [7:0] cpu_ack_vec,
  input wire logic [3:0] cpu_ack_level,
  // Derived CPU level and interrupt
  output logic [3:0] cpu_level,
  output logic user_irq_block,
  output logic irq
);
  logic mem_double_error_trap_flag_reg;
  logic soft_hard_trap_flag_reg;
  logic vector_capture_select_reg;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_mask_reg;
  logic unacked_request_flag;
  logic [7:0] vector_number;
  logic [3:0] new_priority_level;
  logic [15:0] rdata_next;
  logic [15:0] rdata_reg;
  logic wr_trap;
  logic wr_stat;
  logic wr_istat;
  logic wr_imask;

  // ==========================================================
  // Helpers shared by decode and checks
  function automatic logic wr_hit(input logic wr, input logic [3:0] addr,
    input logic [3:0] idx);
    return wr && addr == idx;
  endfunction : wr_hit

  // Vector code that may be shown, top code refused
  function automatic logic vec_usable(input logic [7:0] vec);
    return vec != `TSVR_VEC_RESERVED; // [R8]
  endfunction : vec_usable

  tsvr_ack_if ack_link ();

  // ==========================================================
  // Acknowledge capture
  assign ack_link.ack = cpu_ack;
  assign ack_link.ack_vec = cpu_ack_vec;
  assign ack_link.ack_lvl = cpu_ack_level;

  tsvr_ack_capture u_cap (
    .clk(clk),
    .reset(reset),
    .link(ack_link.unit)
  );

  // ==========================================================
  // Write decode
  assign wr_trap = wr_hit(reg_wr, reg_addr, `TSVR_ADDR_TRAP);
  assign wr_stat = wr_hit(reg_wr, reg_addr, `TSVR_ADDR_STAT);
  assign wr_istat = wr_hit(reg_wr, reg_addr, `TSVR_ADDR_IRQ_STATUS);
  assign wr_imask = wr_hit(reg_wr, reg_addr, `TSVR_ADDR_IRQ_MASK);

  // CPU priority level, top bit blocks user interrupts
  assign cpu_level = {priority_level_msb, priority_level_low}; // [R10]
  assign user_irq_block = priority_level_msb; // [R10]

  // Memory error flag, set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mem_double_error_trap_flag_reg <= 1'b0;
    else if (mem_double_error_event)
      mem_double_error_trap_flag_reg <= 1'b1; // [R1]
    else if (wr_trap && !reg_wdata[`TSVR_BIT_MEM_ERR])
      mem_double_error_trap_flag_reg <= 1'b0; // [R1]
  end

  // Software hard trap flag, set wins over clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      soft_hard_trap_flag_reg <= 1'b0;
    else if (soft_hard_trap_event)
      soft_hard_trap_flag_reg <= 1'b1; // [R2]
    else if (wr_trap && !reg_wdata[`TSVR_BIT_SOFT_TRAP])
      soft_hard_trap_flag_reg <= 1'b0; // [R2]
  end

  // Capture select, only writable bit of the status word
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      vector_capture_select_reg <= 1'b0;
    else if (wr_stat)
      vector_capture_select_reg <= reg_wdata[`TSVR_BIT_CAPSEL];
  end

  // Pending request held back by CPU priority
  assign unacked_request_flag = pend_valid && (cpu_level > pend_level); // [R3]

  // Vector field source select
  always_comb
  begin
    if (vector_capture_select_reg && pend_valid
        && vec_usable(pend_vec)) // [R8]
      vector_number = pend_vec; // [R4]
    else
      vector_number = ack_link.cap_vec; // [R5]
  end
  assign new_priority_level = ack_link.cap_lvl; // [R6] [R11]

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_status_reg <= 2'h0;
    else
      irq_status_reg <= (irq_status_reg & ~(wr_istat ? reg_wdata[1:0] : 2'h0))
        | {mem_double_error_event, soft_hard_trap_event};
  end

  // Interrupt mask
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      irq_mask_reg <= 2'h0;
    else if (wr_imask)
      irq_mask_reg <= reg_wdata[1:0];
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // Read mux, unused bits zero
  always_comb
  begin
    rdata_next = `TSVR_RST_WORD;
    unique case (reg_addr)
      `TSVR_ADDR_TRAP:
        rdata_next = {14'h0000, mem_double_error_trap_flag_reg,
          soft_hard_trap_flag_reg}; // [R9]
      `TSVR_ADDR_STAT:
        rdata_next = {unacked_request_flag, 1'b0, vector_capture_select_reg, 1'b0,
          new_priority_level, vector_number}; // [R9] [R6]
      `TSVR_ADDR_IRQ_STATUS:
        rdata_next = {14'h0000, irq_status_reg};
      `TSVR_ADDR_IRQ_MASK:
        rdata_next = {14'h0000, irq_mask_reg};
      default:
        rdata_next = `TSVR_RST_WORD;
    endcase
  end

  // Read data registered one cycle after strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 16'h0000;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= 16'h0000;
  end
  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Checks
  property p_mem_set;
    @(posedge clk) disable iff (reset)
    mem_double_error_event |=> mem_double_error_trap_flag_reg;
  endproperty
  a_mem_set: assert property (p_mem_set) else $error("mem flag not set"); // [R1]

  property p_soft_set;
    @(posedge clk) disable iff (reset)
    soft_hard_trap_event |=> soft_hard_trap_flag_reg;
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("soft flag not set"); // [R2]

  property p_no_self_set;
    @(posedge clk) disable iff (reset)
    !soft_hard_trap_event && !soft_hard_trap_flag_reg |=> !soft_hard_trap_flag_reg;
  endproperty
  a_no_self_set: assert property (p_no_self_set) else $error("soft flag rose"); // [R2]

  property p_mem_quiet;
    @(posedge clk) disable iff (reset)
    !mem_double_error_event && !mem_double_error_trap_flag_reg
      |=> !mem_double_error_trap_flag_reg;
  endproperty
  a_mem_quiet: assert property (p_mem_quiet) else $error("mem flag rose"); // [R1]

  // Trap flag clear by writing zero, when no event lands
  property p_mem_clear;
    @(posedge clk) disable iff (reset)
    wr_trap && !reg_wdata[`TSVR_BIT_MEM_ERR] && !mem_double_error_event
      |=> !mem_double_error_trap_flag_reg;
  endproperty
  a_mem_clear: assert property (p_mem_clear) else $error("mem flag not cleared"); // [R1]

  property p_soft_clear;
    @(posedge clk) disable iff (reset)
    wr_trap && !reg_wdata[`TSVR_BIT_SOFT_TRAP] && !soft_hard_trap_event
      |=> !soft_hard_trap_flag_reg;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft flag not cleared"); // [R2]

  // Writing one never disturbs a set flag
  property p_mem_keep;
    @(posedge clk) disable iff (reset)
    mem_double_error_trap_flag_reg && !(wr_trap && !reg_wdata[`TSVR_BIT_MEM_ERR])
      |=> mem_double_error_trap_flag_reg;
  endproperty
  a_mem_keep: assert property (p_mem_keep) else $error("mem flag lost"); // [R1]

  // Register read, data stand in the following cycle
  sequence s_read_at(logic [3:0] idx);
    reg_rd && reg_addr == idx;
  endsequence
  property p_trap_rd;
    @(posedge clk) disable iff (reset)
    s_read_at(`TSVR_ADDR_TRAP) |=> reg_rdata[1:0] == $past({mem_double_error_trap_flag_reg,
      soft_hard_trap_flag_reg});
  endproperty
  a_trap_rd: assert property (p_trap_rd) else $error("trap read wrong"); // [R1] [R2]

  property p_trap_zero;
    @(posedge clk) disable iff (reset)
    s_read_at(`TSVR_ADDR_TRAP) |=> reg_rdata[15:2] == 14'h0000;
  endproperty
  a_trap_zero: assert property (p_trap_zero) else $error("trap unused bits set"); // [R9]

  property p_unacked;
    @(posedge clk) disable iff (reset)
    (pend_valid && {priority_level_msb, priority_level_low} > pend_level)
      == unacked_request_flag;
  endproperty
  a_unacked: assert property (p_unacked) else $error("unacked flag wrong"); // [R3]

  property p_live_vec;
    @(posedge clk) disable iff (reset)
    (vector_capture_select_reg && pend_valid && pend_vec != 8'hff)
      |-> vector_number == pend_vec;
  endproperty
  a_live_vec: assert property (p_live_vec) else $error("live vector wrong"); // [R4]

  sequence s_ack;
    cpu_ack && cpu_ack_vec != 8'hff;
  endsequence
  property p_held_vec;
    @(posedge clk) disable iff (reset)
    s_ack ##1 !vector_capture_select_reg |-> vector_number == $past(cpu_ack_vec);
  endproperty
  a_held_vec: assert property (p_held_vec) else $error("held vector wrong"); // [R5]

  // Select clear and no acknowledge: shown vector holds
  sequence s_select_idle;
    !vector_capture_select_reg && !cpu_ack;
  endsequence
  property p_hold_vec;
    @(posedge clk) disable iff (reset)
    s_select_idle ##1 !vector_capture_select_reg |-> $stable(vector_number);
  endproperty
  a_hold_vec: assert property (p_hold_vec) else $error("held vector moved"); // [R5]

  property p_capsel_wr;
    @(posedge clk) disable iff (reset)
    wr_stat |=> vector_capture_select_reg == $past(reg_wdata[`TSVR_BIT_CAPSEL]);
  endproperty
  a_capsel_wr: assert property (p_capsel_wr) else $error("select bit not written"); // [R4]

  property p_refuse_ff;
    @(posedge clk) disable iff (reset)
    cpu_ack && !vec_usable(cpu_ack_vec) |=> $stable(ack_link.cap_vec)
      && $stable(ack_link.cap_lvl);
  endproperty
  a_refuse_ff: assert property (p_refuse_ff) else $error("reserved ack captured"); // [R8]

  property p_level;
    @(posedge clk) disable iff (reset)
    s_ack |=> new_priority_level == $past(cpu_ack_level);
  endproperty
  a_level: assert property (p_level) else $error("new level wrong"); // [R6]

  property p_no_ff;
    @(posedge clk) disable iff (reset)
    vector_number != 8'hff;
  endproperty
  a_no_ff: assert property (p_no_ff) else $error("reserved vector shown"); // [R8]

  property p_zero_bits;
    @(posedge clk) disable iff (reset)
    $past(reg_rd) && $past(reg_addr) == 4'h1 |-> reg_rdata[14] == 1'b0
      && reg_rdata[12] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("unused bits set"); // [R9]

  property p_cpu_lvl;
    @(posedge clk) disable iff (reset)
    priority_level_msb |-> cpu_level[3] && user_irq_block;
  endproperty
  a_cpu_lvl: assert property (p_cpu_lvl) else $error("level top bit wrong"); // [R10]

  property p_lvl_low;
    @(posedge clk) disable iff (reset)
    !priority_level_msb |-> !cpu_level[3] && !user_irq_block
      && cpu_level[2:0] == priority_level_low;
  endproperty
  a_lvl_low: assert property (p_lvl_low) else $error("level low bits wrong"); // [R10]

  property p_stat_unack;
    @(posedge clk) disable iff (reset)
    s_read_at(`TSVR_ADDR_STAT) |=> reg_rdata[`TSVR_BIT_UNACKED]
      == $past(pend_valid && {priority_level_msb, priority_level_low} > pend_level);
  endproperty
  a_stat_unack: assert property (p_stat_unack) else $error("unacked bit read wrong"); // [R3]

  property p_stat_lvl;
    @(posedge clk) disable iff (reset)
    s_read_at(`TSVR_ADDR_STAT) |=> reg_rdata[`TSVR_LVL_HI:`TSVR_LVL_LO]
      == $past(ack_link.cap_lvl) && reg_rdata[7:0] == $past(vector_number);
  endproperty
  a_stat_lvl: assert property (p_stat_lvl) else $error("status level read wrong"); // [R6]

  // Bus and interrupt output housekeeping
  property p_rdata_idle;
    @(posedge clk) disable iff (reset)
    !reg_rd |=> reg_rdata == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_irq_raise;
    @(posedge clk) disable iff (reset)
    |({mem_double_error_event, soft_hard_trap_event} & irq_mask_reg) && !wr_imask |=> irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("unmasked event gave no irq");
endmodule : tsvr_trap_status
`default_nettype wire

// ---- core/tsvr_regs.svh ----
// What this block does
// [R1] Bit 1 of trap flags sets on uncorrectable memory error; software only clears.
// [R2] Bit 0 of trap flags sets on software hard trap; software only clears.
// [R3] Bit 15 shows a request waiting because CPU priority exceeds it.
// [R4] Capture select at bit 13 set: vector field shows highest pending request.
// [R5] Capture select clear: vector field holds the last acknowledged vector.
// [R6] Bits 11 to 8 report new CPU priority level, 0 to 15, read only.
// [R7] Trap vectors: 0 osc, 1 address, 2 hard, 3 stack, 4 math, 6 soft.
// [R8] Peripheral vectors start at 8; vector 255 is never produced.
// [R9] Unused status bits 14, 12 and trap bits 15 to 2 read zero.
// [R10] CPU level joins a top level bit to three low bits; top bit blocks users.
// [R11] New priority updates on acknowledge, same cycle as captured vector.
`ifndef TSVR_REGS_SVH
`define TSVR_REGS_SVH
// ==========================================================
// Register offsets
`define TSVR_ADDR_TRAP 4'h0
`define TSVR_ADDR_STAT 4'h1
`define TSVR_ADDR_IRQ_STATUS 4'h2
`define TSVR_ADDR_IRQ_MASK 4'h3
// ==========================================================
// Field positions
`define TSVR_BIT_SOFT_TRAP 0
`define TSVR_BIT_MEM_ERR 1
`define TSVR_BIT_UNACKED 15
`define TSVR_BIT_CAPSEL 13
`define TSVR_LVL_HI 11
`define TSVR_LVL_LO 8
// ==========================================================
// Reset values and codes
`define TSVR_RST_WORD 16'h0000
`define TSVR_VEC_RESERVED 8'hff
`define TSVR_VEC_FIRST_PERIPH 8'h08
`endif

// ---- core/tsvr_pkg.sv ----
package tsvr_pkg;
  typedef logic [7:0] tsvr_vec_t;
  typedef logic [3:0] tsvr_lvl_t;
  // Trap vector codes, 5 and 7 left unused [R7]
  typedef enum logic [7:0] {
    TSVR_OSC_FAIL = 8'h00,
    TSVR_ADDR_ERR = 8'h01,
    TSVR_HARD_TRAP = 8'h02,
    TSVR_STACK_ERR = 8'h03,
    TSVR_MATH_ERR = 8'h04,
    TSVR_SOFT_ERR = 8'h06
  } tsvr_trap_e;
endpackage : tsvr_pkg

// ---- core/tsvr_ack_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Acknowledge tracking link between top and capture unit
interface tsvr_ack_if;
  logic ack;
  tsvr_pkg::tsvr_vec_t ack_vec;
  tsvr_pkg::tsvr_lvl_t ack_lvl;
  tsvr_pkg::tsvr_vec_t cap_vec;
  tsvr_pkg::tsvr_lvl_t cap_lvl;
  modport top (output ack, output ack_vec, output ack_lvl, input cap_vec, input cap_lvl);
  modport unit (input ack, input ack_vec, input ack_lvl, output cap_vec, output cap_lvl);
endinterface : tsvr_ack_if
`default_nettype wire

// ---- core/tsvr_ack_capture.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tsvr_regs.svh"
// ==========================================================
// Capture of acknowledged vector and level
module tsvr_ack_capture (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Acknowledge link
  tsvr_ack_if.unit link
);
  tsvr_pkg::tsvr_vec_t vec_reg;
  tsvr_pkg::tsvr_lvl_t lvl_reg;

  // Vector and level load together on acknowledge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      vec_reg <= 8'h00;
      lvl_reg <= 4'h0;
    end
    else if (link.ack && link.ack_vec != `TSVR_VEC_RESERVED) // [R8]
    begin
      vec_reg <= link.ack_vec; // [R5]
      lvl_reg <= link.ack_lvl; // [R11]
    end
  end

  assign link.cap_vec = vec_reg;
  assign link.cap_lvl = lvl_reg;

  property p_cap_load;
    @(posedge clk) disable iff (reset)
    (link.ack && link.ack_vec != `TSVR_VEC_RESERVED) |=>
    (vec_reg == $past(link.ack_vec) && lvl_reg == $past(link.ack_lvl));
  endproperty
  a_cap_load: assert property (p_cap_load) else $error("capture did not load"); // [R11]
  property p_cap_hold;
    @(posedge clk) disable iff (reset)
    !link.ack |=> $stable(vec_reg) && $stable(lvl_reg);
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture moved without ack"); // [R5]
endmodule : tsvr_ack_capture
`default_nettype wire

// ---- testbench/tsvr_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// CPU core model: holds priority, acknowledges requests
module tsvr_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bench control
  input wire logic load,
  input wire logic [3:0] lvl,
  input wire logic [1:0] dly,
  // Pending request
  input wire logic pend_valid,
  input wire logic [7:0] pend_vec,
  input wire logic [3:0] pend_level,
  // Core side
  output logic [2:0] priority_level_low,
  output logic priority_level_msb,
  output logic cpu_ack,
  output logic [7:0] cpu_ack_vec,
  output logic [3:0] cpu_ack_level
);
  logic [3:0] cur;
  logic [7:0] avec;
  logic [3:0] alvl;
  logic [1:0] cnt;
  // Level split into low bits and top bit
  assign priority_level_low = cur[2:0];
  assign priority_level_msb = cur[3];
  // Ack lines carry junk outside the pulse
  assign cpu_ack_vec = cpu_ack ? avec : ~avec;
  assign cpu_ack_level = cpu_ack ? alvl : ~alvl;
  // Takes a request above its level after dly cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cur <= 4'h0;
      avec <= 8'h00;
      alvl <= 4'h0;
      cnt <= 2'h0;
      cpu_ack <= 1'b0;
    end
    else
    begin
      cpu_ack <= 1'b0;
      if (load)
      begin
        cur <= lvl;
        cnt <= 2'h0;
      end
      else if (cpu_ack)
      begin
        cur <= alvl;
        cnt <= 2'h0;
      end
      else if (pend_valid && pend_level > cur)
      begin
        if (cnt == dly)
        begin
          cpu_ack <= 1'b1;
          avec <= pend_vec;
          alvl <= pend_level;
        end
        else
          cnt <= cnt + 2'h1;
      end
    end
  end
endmodule : tsvr_cpu_model
`default_nettype wire

// ---- testbench/test_trap_status_and_vector_report.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module test_trap_status_and_vector_report;
  logic clk, reset, reg_wr, reg_rd, me_ev, sh_ev, pend_valid, load, rd_d;
  logic pmsb, cpu_ack, blk, irq;
  logic [2:0] plow;
  logic [1:0] dly;
  logic [3:0] reg_addr, pend_level, lvl, cpu_level, ack_lvl, l;
  logic [7:0] pend_vec, ack_vec, v;
  logic [15:0] reg_wdata, reg_rdata;
  logic [7:0] codes [6];
  logic [15:0] exp_q [$];
  int errors, check_count, i;
  tsvr_trap_status tsvr_trap_status_inst (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_double_error_event(me_ev), .soft_hard_trap_event(sh_ev), .pend_valid(pend_valid),
    .pend_vec(pend_vec), .pend_level(pend_level), .priority_level_low(plow),
    .priority_level_msb(pmsb), .cpu_ack(cpu_ack), .cpu_ack_vec(ack_vec),
    .cpu_ack_level(ack_lvl), .cpu_level(cpu_level), .user_irq_block(blk), .irq(irq));
  tsvr_cpu_model tsvr_cpu_model_inst (.clk(clk), .reset(reset), .load(load), .lvl(lvl),
    .dly(dly), .pend_valid(pend_valid), .pend_vec(pend_vec), .pend_level(pend_level),
    .priority_level_low(plow), .priority_level_msb(pmsb), .cpu_ack(cpu_ack),
    .cpu_ack_vec(ack_vec), .cpu_ack_level(ack_lvl));
  // ==========================================================
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Compare and verdict
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // Register bus cycles and stimulus
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task pulse(input logic sel);
    @(posedge clk);
    me_ev <= sel;
    sh_ev <= ~sel;
    @(posedge clk);
    me_ev <= 1'b0;
    sh_ev <= 1'b0;
  endtask : pulse
  task set_lvl(input logic [3:0] x);
    @(posedge clk);
    load <= 1'b1;
    lvl <= x;
    @(posedge clk);
    load <= 1'b0;
  endtask : set_lvl
  task ack_case(input logic [7:0] vec, input logic [3:0] lv, input logic [15:0] e);
    int n;
    set_lvl(4'h0);
    pend_vec <= vec;
    pend_level <= lv;
    pend_valid <= 1'b1;
    dly <= 2'($urandom % 4);
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (cpu_ack === 1'b1)
        break;
    end
    if (n == 20)
    begin
      errors++;
      wrap_up;
    end
    pend_valid <= 1'b0;
    rd(4'h1, e);
  endtask : ack_case
  // Read monitor takes oldest note
  always @(posedge clk)
  begin
    if (rd_d === 1'b1)
      chk(reg_rdata, exp_q.pop_front());
    rd_d <= reg_rd;
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    reset = 1'b1;
    {reg_wr, reg_rd, me_ev, sh_ev, pend_valid, load} = 6'h00;
    {reg_addr, reg_wdata, pend_vec, pend_level, lvl, dly} = '0;
    errors = 0;
    check_count = 0;
    codes = '{tsvr_pkg::TSVR_OSC_FAIL, tsvr_pkg::TSVR_ADDR_ERR, tsvr_pkg::TSVR_HARD_TRAP,
      tsvr_pkg::TSVR_STACK_ERR, tsvr_pkg::TSVR_MATH_ERR, tsvr_pkg::TSVR_SOFT_ERR};
    void'($urandom(32'h0ba5));
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (i = 0; i < 4; i++)
      rd(i[3:0], 16'h0000);
    rd(4'($urandom % 12 + 4), 16'h0000);
    pulse(1'b1);
    rd(4'h0, 16'h0002);
    rd(4'h2, 16'h0002);
    #1 chk(irq, 16'h0000);
    wr(4'h3, 16'h0003);
    #1 chk(irq, 16'h0001);
    pulse(1'b0);
    rd(4'h0, 16'h0003);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h0003);
    wr(4'h0, 16'h0001);
    rd(4'h0, 16'h0001);
    wr(4'h0, 16'h0000);
    rd(4'h0, 16'h0000);
    wr(4'h3, 16'h0000);
    #1 chk(irq, 16'h0000);
    wr(4'h2, 16'h0003);
    rd(4'h2, 16'h0000);
    wr(4'h3, 16'h0003);
    #1 chk(irq, 16'h0000);
    for (i = 0; i < 16; i++)
    begin
      set_lvl(i[3:0]);
      #1 chk(cpu_level, i[3:0]);
      chk(blk, i[3]);
    end
    set_lvl(4'h5);
    pend_vec <= 8'h08;
    pend_level <= 4'h3;
    pend_valid <= 1'b1;
    rd(4'h1, 16'h8000);
    wr(4'h1, 16'hffff);
    rd(4'h1, 16'ha008);
    wr(4'h1, 16'h0000);
    pend_valid <= 1'b0;
    rd(4'h1, 16'h0000);
    ack_case(8'h09, 4'h9, 16'h0909);
    pend_vec <= 8'h03;
    pend_level <= 4'h4;
    pend_valid <= 1'b1;
    rd(4'h1, 16'h8909);
    wr(4'h1, 16'h2000);
    rd(4'h1, 16'ha903);
    wr(4'h1, 16'h0000);
    pend_valid <= 1'b0;
    ack_case(8'hff, 4'hc, 16'h0909);
    for (i = 0; i < 6; i++)
      ack_case(codes[i], 4'(i + 1), {4'h0, 4'(i + 1), codes[i]});
    ack_case(8'h08, 4'hf, 16'h0f08);
    for (i = 0; i < 4; i++)
    begin
      v = 8'(8 + $urandom % 247);
      l = 4'(1 + $urandom % 15);
      ack_case(v, l, {4'h0, l, v});
    end
    repeat (3) @(posedge clk);
    wrap_up;
  end
endmodule : test_trap_status_and_vector_report
`default_nettype wire
